// file: evt_lock_pkg.sv
// Package: register map, field positions and reset values of the event/lock bank
package evt_lock_pkg;
   // ==========================================
   // Register addresses (7-bit serial address space)
   localparam logic [6:0] ADDR_SYS_EVT_EN  = 7'h04;
   localparam logic [6:0] ADDR_USER_MEM0   = 7'h06;
   localparam logic [6:0] ADDR_USER_MEM3   = 7'h09;
   localparam logic [6:0] ADDR_WP_CTRL     = 7'h0a;
   localparam logic [6:0] ADDR_TRX_EVT_EN  = 7'h23;
   localparam logic [6:0] ADDR_WAKE_EVT_EN = 7'h4c;
   localparam logic [6:0] ADDR_TRX_EVT_ST  = 7'h63;
   localparam logic [6:0] ADDR_WAKE_EVT_ST = 7'h64;
   localparam logic [6:0] ADDR_DEV_ID      = 7'h7e;
   // ==========================================
   // Field positions
   localparam int SERIAL_FAULT_BIT  = 0;
   localparam int OVERTEMP_BIT      = 1;
   localparam int BUS_WAKEUP_BIT    = 0;
   localparam int CAN_FAILURE_BIT   = 1;
   localparam int BUS_SILENCE_BIT   = 4;
   localparam int WAKE_FALL_BIT     = 0;
   localparam int WAKE_RISE_BIT     = 1;
   // ==========================================
   // Writable masks and reset values
   localparam logic [7:0] SYS_EN_MASK   = 8'h03;
   localparam logic [7:0] TRX_EN_MASK   = 8'h13;
   localparam logic [7:0] WAKE_EN_MASK  = 8'h03;
   localparam logic [7:0] TRX_ST_MASK   = 8'h13;
   localparam logic [7:0] WAKE_ST_MASK  = 8'h03;
   localparam logic [7:0] WP_CTRL_MASK  = 8'h7f;
   localparam logic [7:0] RESET_BYTE    = 8'h00;
   localparam logic [1:0] TRX_MODE_ACTIVE = 2'h1;
   // ==========================================
   // Bundles
   typedef struct packed {
      logic       wr_en;
      logic [6:0] addr;
      logic [7:0] data;
   } reg_write_t;
   typedef struct packed {
      logic txd_clamped;
      logic vcc_undervolt;
      logic overtemp;
      logic serial_fault;
      logic bus_silence;
      logic bus_wakeup;
   } event_src_t;
endpackage

// file: event_enable_lock_regs.sv
// Event enables, wake-pin flags, lock control, user memory and device id
// Function
// - CAN failure is taken only in Normal mode with CAN Active, on clamped TXD or undervoltage with mode field 01.
// - A rising edge on the wake pin sets bit 1 of the wake status register; it reads 0 otherwise.
// - A falling edge on the wake pin sets bit 0 of the wake status register; it reads 0 otherwise.
// - System enable bit 1 gates overtemperature, bit 0 gates serial fault; upper bits read-only.
// - Transceiver enable bit 4 gates bus-silence detection; bits 7:5 and 3:2 read-only.
// - Transceiver enable bit 1 gates CAN failure capture.
// - Transceiver enable bit 0 gates remote bus wake-up detection.
// - Wake enable bit 1 gates rising-edge and bit 0 falling-edge detection; bits 7:2 read-only.
// - A read-only identification byte sits at 0x7E.
// - A lock bit at 1 blocks serial writes to its area, at 0 allows them; lock bits are read/write.
// - Lock bits 6..0 cover 68-6F, 50-5F, 40-4F, 30-3F, 20-2F, 10-1F and 06-09.
// - Locking blocks only serial writes; hardware keeps updating flags in locked areas.
// - Four user memory bytes at 0x06 to 0x09 are freely read and written, subject to lock.
// - Bit 7 of the lock register is reserved and read-only.
// - Host clears an event flag by writing 1; writing 0 leaves it.
`timescale 1ns/1ns
module event_enable_lock_regs #(
   parameter logic [7:0] DEVICE_ID = 8'h5a  // Arbitrary value
) (
   input  wire logic                            i_clk,
   input  wire logic                            i_rst_b,
   input  wire evt_lock_pkg::reg_write_t        i_wr,
   input  wire logic [6:0]                      i_rd_addr,
   input  wire evt_lock_pkg::event_src_t        i_evt,
   input  wire logic                            i_normal_mode,
   input  wire logic                            i_can_active,
   input  wire logic [1:0]                      i_transceiver_mode_field,
   input  wire logic                            i_wake_pin,
   output logic [7:0]                           o_rd_data,
   output logic                                 o_can_failure_flag,
   output logic                                 o_wake_rise_flag,
   output logic                                 o_wake_fall_flag,
   output logic                                 o_overtemp_warn_enable,
   output logic                                 o_serial_fault_enable,
   output logic                                 o_bus_silence_enable,
   output logic                                 o_bus_wakeup_enable,
   output logic                                 o_can_failure_enable
);
   // ==========================================
   // Reset synchroniser
   logic rst_meta;
   logic rst_b;
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rst_meta <= 1'b0;
         rst_b    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_b    <= rst_meta;
      end
   end

   // ==========================================
   // Lock decode
   function automatic logic is_locked(input logic [6:0] a, input logic [7:0] lk);
      logic r;
      r = 1'b0;
      if (a >= evt_lock_pkg::ADDR_USER_MEM0 && a <= evt_lock_pkg::ADDR_USER_MEM3)
         r = lk[0];
      else if (a[6:4] == 3'h1) r = lk[1];
      else if (a[6:4] == 3'h2) r = lk[2];
      else if (a[6:4] == 3'h3) r = lk[3];
      else if (a[6:4] == 3'h4) r = lk[4];
      else if (a[6:4] == 3'h5) r = lk[5];
      else if (a[6:3] == 4'hd) r = lk[6];
      return r;
   endfunction

   // ==========================================
   // Register state
   logic [7:0] system_event_enable;
   logic [7:0] transceiver_event_enable;
   logic [7:0] wake_pin_event_enable;
   logic [7:0] write_protect_control;
   logic [7:0] transceiver_event_status;
   logic [7:0] wake_pin_event_status;
   logic [7:0] user_mem [4];
   logic       wake_prev;
   logic [7:0] next_system_event_enable;
   logic [7:0] next_transceiver_event_enable;
   logic [7:0] next_wake_pin_event_enable;
   logic [7:0] next_write_protect_control;
   logic [7:0] next_transceiver_event_status;
   logic [7:0] next_wake_pin_event_status;
   logic [7:0] next_user_mem [4];
   logic       wr_ok;
   logic       can_fail_evt;
   logic       rise_evt;
   logic       fall_evt;
   logic [7:0] trx_set;
   logic [7:0] wake_set;

   always_comb begin
      wr_ok = i_wr.wr_en && !is_locked(i_wr.addr, write_protect_control);
      can_fail_evt = i_normal_mode && i_can_active && (i_evt.txd_clamped ||
         (i_evt.vcc_undervolt &&
          i_transceiver_mode_field == evt_lock_pkg::TRX_MODE_ACTIVE));
      rise_evt = i_wake_pin && !wake_prev;
      fall_evt = !i_wake_pin && wake_prev;
      trx_set = 8'h00;
      trx_set[evt_lock_pkg::CAN_FAILURE_BIT] = can_fail_evt &&
         transceiver_event_enable[evt_lock_pkg::CAN_FAILURE_BIT];
      trx_set[evt_lock_pkg::BUS_SILENCE_BIT] = i_evt.bus_silence &&
         transceiver_event_enable[evt_lock_pkg::BUS_SILENCE_BIT];
      trx_set[evt_lock_pkg::BUS_WAKEUP_BIT] = i_evt.bus_wakeup &&
         transceiver_event_enable[evt_lock_pkg::BUS_WAKEUP_BIT];
      wake_set = 8'h00;
      wake_set[evt_lock_pkg::WAKE_RISE_BIT] = rise_evt &&
         wake_pin_event_enable[evt_lock_pkg::WAKE_RISE_BIT];
      wake_set[evt_lock_pkg::WAKE_FALL_BIT] = fall_evt &&
         wake_pin_event_enable[evt_lock_pkg::WAKE_FALL_BIT];
      next_system_event_enable      = system_event_enable;
      next_transceiver_event_enable = transceiver_event_enable;
      next_wake_pin_event_enable    = wake_pin_event_enable;
      next_write_protect_control    = write_protect_control;
      next_transceiver_event_status = transceiver_event_status;
      next_wake_pin_event_status    = wake_pin_event_status;
      for (int i = 0; i < 4; i++) begin
         next_user_mem[i] = user_mem[i];
      end
      if (wr_ok) begin
         unique case (i_wr.addr)
            evt_lock_pkg::ADDR_SYS_EVT_EN:
               next_system_event_enable = i_wr.data & evt_lock_pkg::SYS_EN_MASK;
            evt_lock_pkg::ADDR_TRX_EVT_EN:
               next_transceiver_event_enable = i_wr.data & evt_lock_pkg::TRX_EN_MASK;
            evt_lock_pkg::ADDR_WAKE_EVT_EN:
               next_wake_pin_event_enable = i_wr.data & evt_lock_pkg::WAKE_EN_MASK;
            evt_lock_pkg::ADDR_WP_CTRL:
               next_write_protect_control = i_wr.data & evt_lock_pkg::WP_CTRL_MASK;
            evt_lock_pkg::ADDR_TRX_EVT_ST:
               next_transceiver_event_status = transceiver_event_status &
                  ~(i_wr.data & evt_lock_pkg::TRX_ST_MASK);
            evt_lock_pkg::ADDR_WAKE_EVT_ST:
               next_wake_pin_event_status = wake_pin_event_status &
                  ~(i_wr.data & evt_lock_pkg::WAKE_ST_MASK);
            default: begin
               if (i_wr.addr >= evt_lock_pkg::ADDR_USER_MEM0 &&
                   i_wr.addr <= evt_lock_pkg::ADDR_USER_MEM3) begin
                  next_user_mem[i_wr.addr[1:0] - 2'd2] = i_wr.data;
               end
            end
         endcase
      end
      // Hardware set wins over a same-cycle clear, lock or not
      next_transceiver_event_status = next_transceiver_event_status | trx_set;
      next_wake_pin_event_status    = next_wake_pin_event_status | wake_set;
   end

   always_ff @(posedge i_clk or negedge rst_b) begin
      if (!rst_b) begin
         system_event_enable      <= evt_lock_pkg::RESET_BYTE;
         transceiver_event_enable <= evt_lock_pkg::RESET_BYTE;
         wake_pin_event_enable    <= evt_lock_pkg::RESET_BYTE;
         write_protect_control    <= evt_lock_pkg::RESET_BYTE;
         transceiver_event_status <= evt_lock_pkg::RESET_BYTE;
         wake_pin_event_status    <= evt_lock_pkg::RESET_BYTE;
         wake_prev                <= 1'b0;
         for (int i = 0; i < 4; i++) begin
            user_mem[i] <= evt_lock_pkg::RESET_BYTE;
         end
      end else begin
         system_event_enable      <= next_system_event_enable;
         transceiver_event_enable <= next_transceiver_event_enable;
         wake_pin_event_enable    <= next_wake_pin_event_enable;
         write_protect_control    <= next_write_protect_control;
         transceiver_event_status <= next_transceiver_event_status;
         wake_pin_event_status    <= next_wake_pin_event_status;
         wake_prev                <= i_wake_pin;
         for (int i = 0; i < 4; i++) begin
            user_mem[i] <= next_user_mem[i];
         end
      end
   end

   // ==========================================
   // Read path, registered
   logic [7:0] next_rd_data;
   always_comb begin
      next_rd_data = 8'h00;
      unique case (i_rd_addr)
         evt_lock_pkg::ADDR_SYS_EVT_EN:  next_rd_data = system_event_enable;
         evt_lock_pkg::ADDR_TRX_EVT_EN:  next_rd_data = transceiver_event_enable;
         evt_lock_pkg::ADDR_WAKE_EVT_EN: next_rd_data = wake_pin_event_enable;
         evt_lock_pkg::ADDR_WP_CTRL:     next_rd_data = write_protect_control;
         evt_lock_pkg::ADDR_TRX_EVT_ST:  next_rd_data = transceiver_event_status;
         evt_lock_pkg::ADDR_WAKE_EVT_ST: next_rd_data = wake_pin_event_status;
         evt_lock_pkg::ADDR_DEV_ID:      next_rd_data = DEVICE_ID;
         default: begin
            if (i_rd_addr >= evt_lock_pkg::ADDR_USER_MEM0 &&
                i_rd_addr <= evt_lock_pkg::ADDR_USER_MEM3) begin
               next_rd_data = user_mem[i_rd_addr[1:0] - 2'd2];
            end
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge rst_b) begin
      if (!rst_b) begin
         o_rd_data <= 8'h00;
      end else begin
         o_rd_data <= next_rd_data;
      end
   end

   assign o_can_failure_flag     = transceiver_event_status[evt_lock_pkg::CAN_FAILURE_BIT];
   assign o_wake_rise_flag       = wake_pin_event_status[evt_lock_pkg::WAKE_RISE_BIT];
   assign o_wake_fall_flag       = wake_pin_event_status[evt_lock_pkg::WAKE_FALL_BIT];
   assign o_overtemp_warn_enable = system_event_enable[evt_lock_pkg::OVERTEMP_BIT];
   assign o_serial_fault_enable  = system_event_enable[evt_lock_pkg::SERIAL_FAULT_BIT];
   assign o_bus_silence_enable   = transceiver_event_enable[evt_lock_pkg::BUS_SILENCE_BIT];
   assign o_bus_wakeup_enable    = transceiver_event_enable[evt_lock_pkg::BUS_WAKEUP_BIT];
   assign o_can_failure_enable   = transceiver_event_enable[evt_lock_pkg::CAN_FAILURE_BIT];

   // ==========================================
   // Assertions
   a_rise_sets_flag: assert property (@(posedge i_clk) disable iff (!rst_b)
      (rise_evt && wake_pin_event_enable[1]) |=> wake_pin_event_status[1])
      else $error("rising edge lost");
   a_fall_sets_flag: assert property (@(posedge i_clk) disable iff (!rst_b)
      (fall_evt && wake_pin_event_enable[0]) |=> wake_pin_event_status[0])
      else $error("falling edge lost");
   a_disabled_no_set: assert property (@(posedge i_clk) disable iff (!rst_b)
      (!wake_pin_event_enable[1] && !wake_pin_event_status[1]) |=> !wake_pin_event_status[1])
      else $error("disabled flag set");
   a_locked_no_write: assert property (@(posedge i_clk) disable iff (!rst_b)
      (i_wr.wr_en && i_wr.addr == evt_lock_pkg::ADDR_USER_MEM0 && write_protect_control[0])
      |=> $stable(user_mem[0]))
      else $error("locked write landed");
   a_mem_write: assert property (@(posedge i_clk) disable iff (!rst_b)
      (i_wr.wr_en && i_wr.addr == evt_lock_pkg::ADDR_USER_MEM3 && !write_protect_control[0])
      |=> user_mem[3] == $past(i_wr.data))
      else $error("memory write missed");
   a_lock_rsvd: assert property (@(posedge i_clk) disable iff (!rst_b)
      !write_protect_control[7])
      else $error("lock bit 7 set");
   a_clear_by_one: assert property (@(posedge i_clk) disable iff (!rst_b)
      (wr_ok && i_wr.addr == evt_lock_pkg::ADDR_WAKE_EVT_ST && i_wr.data[1] && !wake_set[1])
      |=> !wake_pin_event_status[1])
      else $error("flag not cleared");
   a_can_fail_gate: assert property (@(posedge i_clk) disable iff (!rst_b)
      (!i_normal_mode && !transceiver_event_status[1]) |=> !transceiver_event_status[1])
      else $error("CAN failure outside Normal");
   a_id_read: assert property (@(posedge i_clk) disable iff (!rst_b)
      i_rd_addr == evt_lock_pkg::ADDR_DEV_ID |=> o_rd_data == DEVICE_ID)
      else $error("id mismatch");
   // Reserved bits are masked on every write, so they must never read back 1
   a_sys_en_rsvd: assert property (@(posedge i_clk) disable iff (!rst_b)
      (system_event_enable & ~evt_lock_pkg::SYS_EN_MASK) == 8'h00)
      else $error("system enable reserved bit set");
   a_trx_en_rsvd: assert property (@(posedge i_clk) disable iff (!rst_b)
      (transceiver_event_enable & ~evt_lock_pkg::TRX_EN_MASK) == 8'h00)
      else $error("transceiver enable reserved bit set");
   a_wake_en_rsvd: assert property (@(posedge i_clk) disable iff (!rst_b)
      (wake_pin_event_enable & ~evt_lock_pkg::WAKE_EN_MASK) == 8'h00)
      else $error("wake enable reserved bit set");
   a_cf_en_gate: assert property (@(posedge i_clk) disable iff (!rst_b)
      (!transceiver_event_enable[1] && !transceiver_event_status[1])
      |=> !transceiver_event_status[1])
      else $error("disabled CAN failure set");
   a_silence_capture: assert property (@(posedge i_clk) disable iff (!rst_b)
      (i_evt.bus_silence && transceiver_event_enable[4]) |=> transceiver_event_status[4])
      else $error("bus silence lost");
   a_wakeup_capture: assert property (@(posedge i_clk) disable iff (!rst_b)
      (i_evt.bus_wakeup && transceiver_event_enable[0]) |=> transceiver_event_status[0])
      else $error("bus wake-up lost");
   a_txd_fail_capture: assert property (@(posedge i_clk) disable iff (!rst_b)
      (i_normal_mode && i_can_active && i_evt.txd_clamped && transceiver_event_enable[1])
      |=> transceiver_event_status[1])
      else $error("clamped transmit failure lost");
   a_uv_mode_gate: assert property (@(posedge i_clk) disable iff (!rst_b)
      (i_normal_mode && i_can_active && !i_evt.txd_clamped && i_evt.vcc_undervolt &&
       i_transceiver_mode_field != evt_lock_pkg::TRX_MODE_ACTIVE &&
       !transceiver_event_status[1]) |=> !transceiver_event_status[1])
      else $error("undervoltage failure outside mode 01");
   a_locked_hw_set: assert property (@(posedge i_clk) disable iff (!rst_b)
      (write_protect_control[4] && rise_evt && wake_pin_event_enable[1])
      |=> wake_pin_event_status[1])
      else $error("flag update blocked by lock");
   a_lock_reg_write: assert property (@(posedge i_clk) disable iff (!rst_b)
      (i_wr.wr_en && i_wr.addr == evt_lock_pkg::ADDR_WP_CTRL)
      |=> write_protect_control == ($past(i_wr.data) & evt_lock_pkg::WP_CTRL_MASK))
      else $error("lock register write missed");
   a_wake_en_locked: assert property (@(posedge i_clk) disable iff (!rst_b)
      (i_wr.wr_en && i_wr.addr == evt_lock_pkg::ADDR_WAKE_EVT_EN && write_protect_control[4])
      |=> $stable(wake_pin_event_enable))
      else $error("locked wake enable written");
   a_zero_write_keeps: assert property (@(posedge i_clk) disable iff (!rst_b)
      (i_wr.wr_en && i_wr.addr == evt_lock_pkg::ADDR_TRX_EVT_ST && i_wr.data == 8'h00 &&
       transceiver_event_status[1]) |=> transceiver_event_status[1])
      else $error("zero write cleared a flag");
   c_wake_rise: cover property (@(posedge i_clk) disable iff (!rst_b) wake_set[1]);
   c_locked_wr: cover property (@(posedge i_clk) disable iff (!rst_b) i_wr.wr_en && !wr_ok);
   c_can_fail: cover property (@(posedge i_clk) disable iff (!rst_b) trx_set[1]);
   c_wake_fall: cover property (@(posedge i_clk) disable iff (!rst_b) wake_set[0]);
   c_flag_clear: cover property (@(posedge i_clk) disable iff (!rst_b)
      wr_ok && i_wr.addr == evt_lock_pkg::ADDR_TRX_EVT_ST && i_wr.data[1]);
endmodule

// file: host_model.sv
// Host side model: issues register writes on the write strobe bus and reads on the read address port
`timescale 1ns/1ns
module host_model (
   input  wire logic                    i_clk,
   input  wire logic [7:0]              i_rd_data,
   output evt_lock_pkg::reg_write_t     o_wr,
   output logic [6:0]                   o_rd_addr
);
   initial begin
      o_wr = '0;
      o_rd_addr = 7'h00;
   end
   // Strobe stands one full cycle; data inverted after release, never left stale
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(negedge i_clk);
      o_wr = '{wr_en: 1'b1, addr: a, data: d};
      @(negedge i_clk);
      o_wr = '{wr_en: 1'b0, addr: ~a, data: ~d};
   endtask
   // Registered read: data settles one edge after the address
   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      @(negedge i_clk);
      o_rd_addr = a;
      @(negedge i_clk);
      d = i_rd_data;
   endtask
endmodule

// file: tb_top.sv
// Self-checking bench for the event enable and lock register bank
`timescale 1ns/1ns
module tb_top;
   localparam logic [7:0] ID_VAL = 8'h3c;  // Arbitrary value
   logic                     i_clk, i_rst_b, normal, active, pin, prev;
   logic [1:0]               field;
   evt_lock_pkg::reg_write_t wr;
   evt_lock_pkg::event_src_t evt;
   logic [6:0]               rd_addr;
   logic [7:0]               rd_data, e, sh [128];
   logic [31:0]              r;
   integer                   seed;
   logic                     cf_f, rise_f, fall_f, otw_en, spi_en, sil_en, wk_en, cf_en;
   int                       num_errors, cmp_count;
   logic [6:0]               probe [6] = '{7'h04, 7'h06, 7'h09, 7'h23, 7'h4c, 7'h7e};

   host_model host (.i_clk(i_clk), .i_rd_data(rd_data), .o_wr(wr), .o_rd_addr(rd_addr));
   event_enable_lock_regs #(.DEVICE_ID(ID_VAL)) dut (
      .i_clk(i_clk), .i_rst_b(i_rst_b), .i_wr(wr), .i_rd_addr(rd_addr), .i_evt(evt),
      .i_normal_mode(normal), .i_can_active(active), .i_transceiver_mode_field(field),
      .i_wake_pin(pin), .o_rd_data(rd_data), .o_can_failure_flag(cf_f),
      .o_wake_rise_flag(rise_f), .o_wake_fall_flag(fall_f), .o_overtemp_warn_enable(otw_en),
      .o_serial_fault_enable(spi_en), .o_bus_silence_enable(sil_en),
      .o_bus_wakeup_enable(wk_en), .o_can_failure_enable(cf_en));

   // ==========================================
   // Helpers
   initial begin
      i_clk = 1'b0;
      forever #10 i_clk = ~i_clk;
   end
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic summarize;
      $display("checks %0d errors %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   function automatic logic [7:0] msk(input logic [6:0] a);
      case (a)
         7'h04: return evt_lock_pkg::SYS_EN_MASK;
         7'h06, 7'h07, 7'h08, 7'h09: return 8'hff;
         7'h0a: return evt_lock_pkg::WP_CTRL_MASK;
         7'h23: return evt_lock_pkg::TRX_EN_MASK;
         7'h4c: return evt_lock_pkg::WAKE_EN_MASK;
         default: return 8'h00;
      endcase
   endfunction
   function automatic logic covered(input logic [6:0] a, input logic [7:0] lk);
      return (a >= 7'h06 && a <= 7'h09 && lk[0]) || (a >= 7'h68 && a <= 7'h6f && lk[6])
         || (a[6:4] inside {3'h1, 3'h2, 3'h3, 3'h4, 3'h5} && lk[a[6:4]]);
   endfunction
   // Write with shadow update; locked targets keep their old value
   task automatic tw(input logic [6:0] a, input logic [7:0] d);
      host.wr(a, d);
      if (!covered(a, sh[10])) sh[a] = d & msk(a);
   endtask
   task automatic rchk(input logic [6:0] a, input logic [7:0] exp);
      logic [7:0] d;
      host.rd(a, d);
      check($sformatf("reg %h", a), d, exp);
   endtask
   task automatic sweep;
      for (int a = 0; a < 128; a++) begin
         if (a == 8'h63 || a == 8'h64) continue;
         rchk(a[6:0], (a == 8'h7e) ? ID_VAL : sh[a]);
      end
      check("sys_en", {6'h0, otw_en, spi_en}, sh[4]);
      check("trx_en", {3'h0, sil_en, 2'h0, cf_en, wk_en}, sh[35]);
   endtask

   // ==========================================
   // Main sequence
   initial begin
      seed = 32'h49aa;
      i_rst_b = 1'b0;
      evt = '0;
      {normal, active, pin, prev, field} = '0;
      foreach (sh[i]) sh[i] = evt_lock_pkg::RESET_BYTE;
      repeat (20) @(negedge i_clk);
      i_rst_b = 1'b1;
      repeat (4) @(negedge i_clk);
      sweep();
      for (int b = 0; b < 8; b++) begin
         tw(7'h0a, 8'h01 << b);
         foreach (probe[k]) begin
            r = $random(seed);
            tw(probe[k], r[7:0]);
         end
         sweep();
      end
      tw(7'h0a, 8'h00);
      for (int n = 0; n < 300; n++) begin
         r = $random(seed);
         if (r[6:0] != 7'h63 && r[6:0] != 7'h64) tw(r[6:0], r[15:8]);
      end
      sweep();
      tw(7'h0a, 8'h00);
      tw(7'h4c, 8'h00);
      for (int n = 0; n < 48; n++) begin
         r = $random(seed);
         tw(7'h23, r[7:0]);
         @(negedge i_clk);
         {evt, normal, active, field} = r[17:8];
         @(negedge i_clk);
         evt = '0;
         repeat (2) @(negedge i_clk);
         // Slice order: txd, undervolt, overtemp, serial fault, silence, wakeup, normal, active, field
         e = {3'h0, r[13] & r[4], 2'h0,
            r[1] & r[11] & r[10] & (r[17] | (r[16] & (r[9:8] == 2'b01))), r[12] & r[0]};
         rchk(7'h63, e);
         check("cf_flag", {7'h0, cf_f}, {7'h0, e[1]});
         host.wr(7'h63, 8'h00);
         rchk(7'h63, e);
         host.wr(7'h63, 8'hff);
         rchk(7'h63, 8'h00);
      end
      for (int n = 0; n < 48; n++) begin
         r = $random(seed);
         tw(7'h0a, 8'h00);
         tw(7'h4c, r[7:0]);
         tw(7'h0a, 8'h7f);
         @(negedge i_clk);
         pin = r[8];
         repeat (4) @(negedge i_clk);
         e = {6'h0, r[1] & r[8] & ~prev, r[0] & ~r[8] & prev};
         rchk(7'h64, e);
         check("wake_flags", {6'h0, rise_f, fall_f}, e);
         host.wr(7'h64, 8'hff);
         rchk(7'h64, 8'h00);
         prev = r[8];
      end
      summarize();
   end

   initial begin
      #400000;
      num_errors++;
      summarize();
   end
endmodule
